/* File: sllc_defs.vh */
// Constants for the serial link lane configuration block
`ifndef SLLC_DEFS_VH
`define SLLC_DEFS_VH
// Register indices; byte address is index times four
`define SLLC_IDX_LANE_RATE   11'h56e
`define SLLC_IDX_QUICK       11'h570
`define SLLC_IDX_LINK_CTRL   11'h580
`define SLLC_IDX_FRAMES_MF   11'h581
`define SLLC_IDX_STATUS      11'h582
`define SLLC_IDX_RATE        11'h583
`define SLLC_IDX_ADC_CLK     11'h584
`define SLLC_IDX_DEEMPH_EN   11'h5c1
`define SLLC_IDX_DEEMPH_LVL0 11'h5c2
`define SLLC_IDX_DEEMPH_LVL3 11'h5c5
// Reset values
`define SLLC_RST_LANE_RATE   8'h00
`define SLLC_RST_QUICK       8'h88
`define SLLC_RST_FRAMES_MF   6'h20
`define SLLC_RST_ADC_CLK     16'h03e8
// Fields
`define SLLC_LOW_RATE_BIT    4
`define SLLC_PLL_MSB         4
`define SLLC_PLL_LSB         3
`define SLLC_CTRL_POWER_UP   0
`define SLLC_CTRL_NPRIME8    1
`define SLLC_CTRL_DEC_MSB    5
`define SLLC_CTRL_DEC_LSB    4
// Lane rate limits in Mbps and frames-per-multiframe limit
`define SLLC_RATE_MIN_MBPS   28'h000_0c35
`define SLLC_RATE_LOW_MBPS   28'h000_186a
`define SLLC_RATE_MAX_MBPS   28'h000_30d4
`define SLLC_FRAMES_MF_MAX   6'h20
// Encoding and sample widths
`define SLLC_LINE_NUM        4'ha
`define SLLC_LINE_DEN_SHIFT  3
`define SLLC_NPRIME16        5'h10
`define SLLC_NPRIME8         5'h08
`endif

/* File: sllc_lane_config.v */
// Lane configuration, rate checking, de-emphasis and lane mapping for one serial link
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "sllc_defs.vh"
module sllc_lane_config (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        reset,
  // Avalon-MM slave
  input  wire [12:0] address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  output reg  [31:0] readdata,
  output wire        waitrequest,
  // Parallel link data in
  input  wire [31:0] link_octets,
  input  wire        link_valid,
  output wire        link_ready,
  // Lanes out
  output reg  [7:0]  serial_lane_out_first,
  output reg  [7:0]  serial_lane_out_second,
  output reg  [7:0]  serial_lane_out_third,
  output reg  [7:0]  serial_lane_out_last,
  output reg  [3:0]  lane_active,
  // Serializer and driver controls
  output wire [1:0]  serializer_rate_sel,
  output wire        low_line_rate,
  output wire [3:0]  deemph_enable,
  output wire [15:0] deemph_level,
  // Decoded link parameters
  output reg  [2:0]  param_lanes,
  output reg  [2:0]  param_converters,
  output reg  [4:0]  param_octets,
  output reg  [3:0]  param_samples,
  output reg         param_hd,
  output wire        code_unsupported
);

  ////////////////////////////////////////////////////////////////////////
  reg  [7:0]  lane_rate_control;
  reg  [7:0]  link_quick_setup;
  reg  [5:0]  link_ctrl;
  reg  [5:0]  frames_mf;
  reg  [15:0] adc_clk_mhz;
  reg  [3:0]  deemph_en;
  reg  [3:0]  deemph_lvl [0:3];
  reg         ack;
  reg  [27:0] rate_mbps;
  wire [10:0] idx;
  wire        req;
  wire        link_up;
  wire [4:0]  nprime;
  reg  [16:0] dec;
  reg  [31:0] next_readdata;
  integer     i;

  assign idx         = address[12:2];
  assign req         = read | write;
  assign waitrequest = req & ~ack;
  assign link_up     = link_ctrl[`SLLC_CTRL_POWER_UP];
  assign nprime      = link_ctrl[`SLLC_CTRL_NPRIME8] ? `SLLC_NPRIME8 : `SLLC_NPRIME16;

  ////////////////////////////////////////////////////////////////////////
  // Quick code decode: {valid, L, M, F, S, HD}
  function [16:0] sllc_decode;
    input       n8;
    input [7:0] code;
    begin
      sllc_decode = 17'h0_0000;
      if (!n8) begin
        case (code)
          8'h01: sllc_decode = {1'b1, 3'd1, 3'd1, 5'd2, 4'd1, 1'b0};
          8'h40: sllc_decode = {1'b1, 3'd2, 3'd1, 5'd1, 4'd1, 1'b1};
          8'h41: sllc_decode = {1'b1, 3'd2, 3'd1, 5'd2, 4'd2, 1'b0};
          8'h80: sllc_decode = {1'b1, 3'd4, 3'd1, 5'd1, 4'd2, 1'b1};
          8'h81: sllc_decode = {1'b1, 3'd4, 3'd1, 5'd2, 4'd4, 1'b0};
          8'h0a: sllc_decode = {1'b1, 3'd1, 3'd2, 5'd4, 4'd1, 1'b0};
          8'h49: sllc_decode = {1'b1, 3'd2, 3'd2, 5'd2, 4'd1, 1'b0};
          8'h88: sllc_decode = {1'b1, 3'd4, 3'd2, 5'd1, 4'd1, 1'b1};
          8'h89: sllc_decode = {1'b1, 3'd4, 3'd2, 5'd2, 4'd2, 1'b0};
          8'h13: sllc_decode = {1'b1, 3'd1, 3'd4, 5'd8, 4'd1, 1'b0};
          8'h52: sllc_decode = {1'b1, 3'd2, 3'd4, 5'd4, 4'd1, 1'b0};
          8'h91: sllc_decode = {1'b1, 3'd4, 3'd4, 5'd2, 4'd1, 1'b0};
          default: sllc_decode = 17'h0_0000;
        endcase
      end else begin
        case (code)
          8'h00: sllc_decode = {1'b1, 3'd1, 3'd1, 5'd1, 4'd1, 1'b0};
          8'h01: sllc_decode = {1'b1, 3'd1, 3'd1, 5'd2, 4'd2, 1'b0};
          8'h40: sllc_decode = {1'b1, 3'd2, 3'd1, 5'd1, 4'd2, 1'b0};
          8'h41: sllc_decode = {1'b1, 3'd2, 3'd1, 5'd2, 4'd4, 1'b0};
          8'h42: sllc_decode = {1'b1, 3'd2, 3'd1, 5'd4, 4'd8, 1'b0};
          8'h80: sllc_decode = {1'b1, 3'd4, 3'd1, 5'd1, 4'd4, 1'b0};
          8'h81: sllc_decode = {1'b1, 3'd4, 3'd1, 5'd2, 4'd8, 1'b0};
          8'h09: sllc_decode = {1'b1, 3'd1, 3'd2, 5'd2, 4'd1, 1'b0};
          8'h48: sllc_decode = {1'b1, 3'd2, 3'd2, 5'd1, 4'd1, 1'b0};
          8'h49: sllc_decode = {1'b1, 3'd2, 3'd2, 5'd2, 4'd2, 1'b0};
          8'h88: sllc_decode = {1'b1, 3'd4, 3'd2, 5'd1, 4'd2, 1'b0};
          8'h89: sllc_decode = {1'b1, 3'd4, 3'd2, 5'd2, 4'd4, 1'b0};
          8'h8a: sllc_decode = {1'b1, 3'd4, 3'd2, 5'd4, 4'd8, 1'b0};
          default: sllc_decode = 17'h0_0000;
        endcase
      end
    end
  endfunction

  always @* begin
    dec = sllc_decode(link_ctrl[`SLLC_CTRL_NPRIME8], link_quick_setup);
  end

  assign code_unsupported = ~dec[16];

  always @(posedge clk_sys) begin
    if (reset) begin
      param_lanes      <= 3'd4;
      param_converters <= 3'd2;
      param_octets     <= 5'd1;
      param_samples    <= 4'd1;
      param_hd         <= 1'b1;
    end else if (dec[16]) begin
      param_lanes      <= dec[15:13];
      param_converters <= dec[12:10];
      param_octets     <= dec[9:5];
      param_samples    <= dec[4:1];
      param_hd         <= dec[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // lane rate in Mbps from converter clock and decimation
  wire [27:0] rate_num;
  wire [2:0]  lane_shift;
  // Product of M and N', not their concatenation; 28 bits hold the largest case
  assign rate_num   = {25'h000_0000, param_converters} * {23'h00_0000, nprime} * `SLLC_LINE_NUM *
                      {12'h000, adc_clk_mhz};
  assign lane_shift = (param_lanes == 3'd4) ? 3'd2 : ((param_lanes == 3'd2) ? 3'd1 : 3'd0);

  always @(posedge clk_sys) begin
    if (reset) begin
      rate_mbps <= 28'h000_0000;
    end else begin
      rate_mbps <= ((rate_num >> `SLLC_LINE_DEN_SHIFT) >> lane_shift) >> link_ctrl[`SLLC_CTRL_DEC_MSB:`SLLC_CTRL_DEC_LSB];
    end
  end

  wire rate_out_of_range;
  assign rate_out_of_range = (rate_mbps < `SLLC_RATE_MIN_MBPS) | (rate_mbps > `SLLC_RATE_MAX_MBPS);

  // low rate setting expected below limit
  wire low_rate_needed;
  assign low_rate_needed = rate_mbps < `SLLC_RATE_LOW_MBPS;

  wire low_rate_mismatch;
  assign low_rate_mismatch = lane_rate_control[`SLLC_LOW_RATE_BIT] ^ low_rate_needed;

  assign serializer_rate_sel = lane_rate_control[`SLLC_PLL_MSB:`SLLC_PLL_LSB];
  assign low_line_rate       = lane_rate_control[`SLLC_LOW_RATE_BIT];

  reg [5:0] k_min;
  always @* begin
    case (param_octets)
      5'd1:    k_min = 6'd20;
      5'd2:    k_min = 6'd12;
      5'd4:    k_min = 6'd8;
      default: k_min = 6'd4;
    endcase
  end
  wire k_invalid;
  assign k_invalid = (frames_mf[1:0] != 2'b00) | (frames_mf > `SLLC_FRAMES_MF_MAX) | (frames_mf < k_min);

  ////////////////////////////////////////////////////////////////////////
  // de-emphasis off after reset
  assign deemph_enable = deemph_en;
  assign deemph_level  = {deemph_lvl[3], deemph_lvl[2], deemph_lvl[1], deemph_lvl[0]};

  // Register writes take effect on the acknowledge edge
  always @(posedge clk_sys) begin
    if (reset) begin
      lane_rate_control <= `SLLC_RST_LANE_RATE;
      link_quick_setup  <= `SLLC_RST_QUICK;
      link_ctrl         <= 6'h00;
      frames_mf         <= `SLLC_RST_FRAMES_MF;
      adc_clk_mhz       <= `SLLC_RST_ADC_CLK;
      deemph_en         <= 4'h0;
      for (i = 0; i < 4; i = i + 1) begin
        deemph_lvl[i] <= 4'h0;
      end
    end else if (write & ack) begin
      if (idx == `SLLC_IDX_LANE_RATE) begin
        lane_rate_control <= writedata[7:0];
      end else if (idx == `SLLC_IDX_QUICK) begin
        link_quick_setup <= writedata[7:0];
      end else if (idx == `SLLC_IDX_LINK_CTRL) begin
        link_ctrl <= writedata[5:0];
      end else if (idx == `SLLC_IDX_FRAMES_MF) begin
        frames_mf <= writedata[5:0];
      end else if (idx == `SLLC_IDX_ADC_CLK) begin
        adc_clk_mhz <= writedata[15:0];
      end else if (idx == `SLLC_IDX_DEEMPH_EN) begin
        deemph_en <= writedata[3:0];
      end else if (idx >= `SLLC_IDX_DEEMPH_LVL0 && idx <= `SLLC_IDX_DEEMPH_LVL3) begin
        deemph_lvl[idx[1:0] - 2'd2] <= writedata[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // One wait state on every access; unmapped reads return zero
  always @* begin
    next_readdata = 32'h0000_0000;
    if (idx == `SLLC_IDX_LANE_RATE) begin
      next_readdata = {24'h00_0000, lane_rate_control};
    end else if (idx == `SLLC_IDX_QUICK) begin
      next_readdata = {24'h00_0000, link_quick_setup};
    end else if (idx == `SLLC_IDX_LINK_CTRL) begin
      next_readdata = {26'h000_0000, link_ctrl};
    end else if (idx == `SLLC_IDX_FRAMES_MF) begin
      next_readdata = {26'h000_0000, frames_mf};
    end else if (idx == `SLLC_IDX_STATUS) begin
      next_readdata = {8'h00, param_hd, param_samples, param_octets, param_converters, param_lanes,
                       4'h0, k_invalid, low_rate_mismatch, rate_out_of_range, code_unsupported};
    end else if (idx == `SLLC_IDX_RATE) begin
      next_readdata = {4'h0, rate_mbps};
    end else if (idx == `SLLC_IDX_ADC_CLK) begin
      next_readdata = {16'h0000, adc_clk_mhz};
    end else if (idx == `SLLC_IDX_DEEMPH_EN) begin
      next_readdata = {28'h000_0000, deemph_en};
    end else if (idx >= `SLLC_IDX_DEEMPH_LVL0 && idx <= `SLLC_IDX_DEEMPH_LVL3) begin
      next_readdata = {28'h000_0000, deemph_lvl[idx[1:0] - 2'd2]};
    end
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      ack      <= 1'b0;
      readdata <= 32'h0000_0000;
    end else begin
      ack <= req & ~ack;
      if (read & ~ack) begin
        readdata <= next_readdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // lanes run only once powered up
  assign link_ready = link_up;

  always @(posedge clk_sys) begin
    if (reset) begin
      serial_lane_out_first  <= 8'h00;
      serial_lane_out_second <= 8'h00;
      serial_lane_out_third  <= 8'h00;
      serial_lane_out_last   <= 8'h00;
      lane_active            <= 4'h0;
    end else begin
      lane_active[0] <= link_up;
      lane_active[1] <= link_up & (param_lanes != 3'd1);
      lane_active[2] <= link_up & (param_lanes == 3'd4);
      lane_active[3] <= link_up & (param_lanes == 3'd4);
      if (link_up & link_valid) begin
        serial_lane_out_first  <= link_octets[7:0];
        serial_lane_out_second <= (param_lanes != 3'd1) ? link_octets[15:8] : 8'h00;
        serial_lane_out_third  <= (param_lanes == 3'd4) ? link_octets[23:16] : 8'h00;
        serial_lane_out_last   <= (param_lanes == 3'd4) ? link_octets[31:24] : 8'h00;
      end
    end
  end

endmodule

/* File: sllc_lane_config_assertions.sv */
// Checker for the serial link lane configuration block
`timescale 1ns/1ps
module sllc_checks (
  // Clock, reset and bus
  input wire        clk_sys,
  input wire        reset,
  input wire        read,
  input wire        write,
  input wire        waitrequest,
  // Link
  input wire        link_ready,
  input wire        link_valid,
  input wire [31:0] link_octets,
  input wire [7:0]  serial_lane_out_first,
  input wire [7:0]  serial_lane_out_last,
  // Configuration
  input wire        low_line_rate,
  input wire [1:0]  serializer_rate_sel,
  input wire [2:0]  param_lanes,
  input wire [4:0]  param_octets,
  input wire        param_hd,
  input wire        code_unsupported
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  wire beat = link_ready && link_valid;
  ////////////////////////////////////////
  a_one_wait: assert property ($rose(read || write) |-> waitrequest ##1 !waitrequest)
    else $error("wait state wrong");
  a_lane_load: assert property (beat |=> serial_lane_out_first == $past(link_octets[7:0]))
    else $error("lane 0 not loaded");
  a_lane_hold: assert property (!beat |=> $stable(serial_lane_out_first))
    else $error("lane 0 moved");
  a_lane_zero: assert property (beat && param_lanes == 3'd2 |=> serial_lane_out_last == 8'h00)
    else $error("unused lane not zero");
  a_rate_tie: assert property (low_line_rate == serializer_rate_sel[1])
    else $error("rate field split");
  a_rate_hold: assert property (!write |=> $stable(serializer_rate_sel))
    else $error("rate field moved");
  a_hd_single: assert property (param_hd |-> param_octets == 5'd1)
    else $error("dense mode with wide frame");
  a_lane_count: assert property ($onehot(param_lanes))
    else $error("bad lane count");
  a_unsup_keep: assert property (code_unsupported && !write |=> $stable({param_lanes, param_octets, param_hd}))
    else $error("params changed on bad code");
  cover property (code_unsupported);
  cover property (beat && param_lanes == 3'd2);
  cover property (low_line_rate);
endmodule

bind sllc_lane_config sllc_checks sllc_checks_i (
  .clk_sys(clk_sys), .reset(reset), .read(read), .write(write), .waitrequest(waitrequest),
  .link_ready(link_ready), .link_valid(link_valid), .link_octets(link_octets),
  .serial_lane_out_first(serial_lane_out_first), .serial_lane_out_last(serial_lane_out_last),
  .low_line_rate(low_line_rate), .serializer_rate_sel(serializer_rate_sel), .param_lanes(param_lanes),
  .param_octets(param_octets), .param_hd(param_hd), .code_unsupported(code_unsupported));

/* File: sllc_rx_model.sv */
// Receiver model that gathers the four lane octets of the link
`timescale 1ns/1ps
module sllc_rx_model (
  // Clock and lanes
  input  wire       clk_sys,
  input  wire [7:0] lane0,
  input  wire [7:0] lane1,
  input  wire [7:0] lane2,
  input  wire [7:0] lane3,
  // Gathered word
  output reg [31:0] rx_word
);
  always @(posedge clk_sys) begin
    rx_word <= {lane3, lane2, lane1, lane0};
  end
endmodule

/* File: sllc_lane_config_bench.sv */
// Self-checking bench for the serial link lane configuration block
`timescale 1ns/1ps
`include "sllc_defs.vh"
module sllc_lane_config_bench;
  reg         clk_sys = 0, reset = 1, read = 0, write = 0, link_valid = 0;
  reg  [12:0] address = 0;
  reg  [31:0] writedata = 0, link_octets = 0, rd_val;
  wire [31:0] readdata, rx_word;
  wire        waitrequest, link_ready, low_line_rate, code_unsupported, param_hd;
  wire [7:0]  l0, l1, l2, l3;
  wire [3:0]  lane_active, deemph_enable, param_samples;
  wire [1:0]  serializer_rate_sel;
  wire [15:0] deemph_level;
  wire [2:0]  param_lanes, param_converters;
  wire [4:0]  param_octets;
  wire [15:0] prm = {param_lanes, param_converters, param_octets, param_samples, param_hd};
  integer     num_errors = 0, num_checks = 0, i;
  // Code, L, M, F, S, HD; first twelve at 16-bit width, rest at 8-bit
  logic [27:0] tab [0:24] = '{28'h011_1210, 28'h402_1111, 28'h412_1220, 28'h804_1121, 28'h814_1240,
    28'h0a1_2410, 28'h492_2210, 28'h884_2111, 28'h894_2220, 28'h131_4810, 28'h522_4410, 28'h914_4210,
    28'h001_1110, 28'h011_1220, 28'h402_1120, 28'h412_1240, 28'h422_1480, 28'h804_1140, 28'h814_1280,
    28'h091_2210, 28'h482_2110, 28'h492_2220, 28'h884_2120, 28'h894_2240, 28'h8a4_2480};
  sllc_lane_config sllc_lane_config_i (.clk_sys(clk_sys), .reset(reset), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .link_octets(link_octets), .link_valid(link_valid), .link_ready(link_ready),
    .serial_lane_out_first(l0), .serial_lane_out_second(l1), .serial_lane_out_third(l2),
    .serial_lane_out_last(l3), .lane_active(lane_active), .serializer_rate_sel(serializer_rate_sel),
    .low_line_rate(low_line_rate), .deemph_enable(deemph_enable), .deemph_level(deemph_level),
    .param_lanes(param_lanes), .param_converters(param_converters), .param_octets(param_octets),
    .param_samples(param_samples), .param_hd(param_hd), .code_unsupported(code_unsupported));
  sllc_rx_model sllc_rx_model_i (.clk_sys(clk_sys), .lane0(l0), .lane1(l1), .lane2(l2), .lane3(l3),
    .rx_word(rx_word));
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////
  function [15:0] pk(input [27:0] e);
    pk = {e[18:16], e[14:12], 1'b0, e[11:8], e[7:4], e[0]};
  endfunction
  task test_done;
    begin
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("wrong value %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  // Holds the request until waitrequest is sampled low, then releases it
  task bus(input wr, input [10:0] idx, input [31:0] d);
    integer n;
    begin
      address <= {idx, 2'b00};
      writedata <= d;
      write <= wr;
      read <= !wr;
      n = 0;
      do begin @(posedge clk_sys); n = n + 1; end while (waitrequest !== 1'b0 && n < 50);
      if (waitrequest !== 1'b0) begin num_errors = num_errors + 1; test_done; end
      rd_val = readdata;
      read <= 0;
      write <= 0;
      @(posedge clk_sys);
    end
  endtask
  ////////////////////////////////////////
  task t_reset;
    begin
      bus(0, `SLLC_IDX_QUICK, 0);
      chk("quick", rd_val, 32'h0000_0088);
      chk("params", prm, pk(tab[7]));
      chk("deemph", deemph_enable, 0);
    end
  endtask
  task t_codes;
    begin
      bus(1, `SLLC_IDX_LINK_CTRL, 0);
      for (i = 0; i < 25; i = i + 1) begin
        if (i == 12) bus(1, `SLLC_IDX_LINK_CTRL, 32'h0000_0002);
        bus(1, `SLLC_IDX_QUICK, {24'h0, tab[i][27:20]});
        @(posedge clk_sys);
        chk("params", prm, pk(tab[i]));
        chk("unsup", code_unsupported, 0);
      end
    end
  endtask
  task t_unsup;
    begin
      bus(1, `SLLC_IDX_QUICK, 32'h0000_0013);
      @(posedge clk_sys);
      chk("unsup", code_unsupported, 1);
      chk("kept", prm, pk(tab[24]));
      bus(0, `SLLC_IDX_STATUS, 0);
      chk("status", rd_val[0], 1);
      bus(1, `SLLC_IDX_LINK_CTRL, 0);
      @(posedge clk_sys);
      chk("wide", prm, pk(tab[9]));
    end
  endtask
  // Four lanes, two converters, decimation 2 at 1000 MHz gives 5000 Mbps
  task t_rate;
    begin
      bus(1, `SLLC_IDX_QUICK, 32'h0000_0088);
      bus(1, `SLLC_IDX_LINK_CTRL, 32'h0000_0010);
      bus(1, `SLLC_IDX_LANE_RATE, 32'h0000_0010);
      bus(0, `SLLC_IDX_RATE, 0);
      chk("rate", rd_val, 32'h0000_1388);
      chk("pll", {low_line_rate, serializer_rate_sel}, 3'b110);
      bus(0, `SLLC_IDX_STATUS, 0);
      chk("flags", rd_val[3:0], 4'h0);
      bus(1, `SLLC_IDX_LANE_RATE, 0);
      bus(1, `SLLC_IDX_FRAMES_MF, 32'h0000_0010);
      bus(0, `SLLC_IDX_STATUS, 0);
      chk("flags", rd_val[3:0], 4'hc);
      bus(1, `SLLC_IDX_FRAMES_MF, 32'h0000_0014);
      bus(1, `SLLC_IDX_LINK_CTRL, 32'h0000_0030);
      bus(0, `SLLC_IDX_STATUS, 0);
      chk("flags", rd_val[3:0], 4'h6);
    end
  endtask
  task t_link;
    begin
      link_octets <= 32'h4433_2211;
      link_valid <= 1;
      repeat (3) @(posedge clk_sys);
      chk("ready", {31'h0, link_ready}, 0);
      chk("down", rx_word, 0);
      chk("active", {28'h0, lane_active}, 0);
      bus(1, `SLLC_IDX_LINK_CTRL, 32'h0000_0011);
      repeat (2) @(posedge clk_sys);
      chk("ready", {31'h0, link_ready}, 32'h0000_0001);
      chk("four", rx_word, 32'h4433_2211);
      chk("active", {28'h0, lane_active}, 32'h0000_000f);
      bus(1, `SLLC_IDX_QUICK, 32'h0000_0049);
      link_octets <= 32'h8877_6655;
      repeat (3) @(posedge clk_sys);
      chk("two", rx_word, 32'h0000_6655);
      chk("active", {28'h0, lane_active}, 32'h0000_0003);
      link_valid <= 0;
      link_octets <= 32'h1234_5678;
      repeat (3) @(posedge clk_sys);
      chk("hold", rx_word, 32'h0000_6655);
    end
  endtask
  task t_deemph;
    begin
      bus(1, `SLLC_IDX_DEEMPH_EN, 32'h0000_0005);
      bus(1, `SLLC_IDX_DEEMPH_LVL3, 32'h0000_0009);
      chk("deemph", {deemph_enable, deemph_level}, 20'h5_9000);
      bus(1, 11'h5c0, 32'h0000_00ff);
      bus(0, 11'h5c0, 0);
      chk("unmapped", rd_val, 0);
    end
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk_sys);
    reset <= 0;
    @(posedge clk_sys);
    t_reset;
    t_codes;
    t_unsup;
    t_rate;
    t_link;
    t_deemph;
    test_done;
  end
endmodule
